// ---- pkg/step_pkg.sv ----
package step_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int UNIT_NS       = 1000;
  localparam int UNIT_CYC      = (UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Word layout
  // ---------------------------------------------------------------
  localparam int         WORD_W      = 16;
  localparam int         SEL_LSB     = 13;
  localparam int         FIELD_W     = 13;
  localparam logic [2:0] SEL_PROFILE = 3'h3;
  localparam logic [2:0] SEL_PERIOD  = 3'h4;
  localparam logic [2:0] SEL_COUNT   = 3'h5;
  localparam int         MULT_LSB    = 0;
  localparam int         DIV_LSB     = 2;
  localparam int         TBL_LSB     = 5;
  localparam int         TIME_LSB    = 7;
  localparam int         DEC_EN_BIT  = 9;
  localparam int         ACC_EN_BIT  = 10;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [12:0] PROFILE_RST = 13'h0000;
  localparam logic [12:0] PERIOD_RST  = 13'h0000;
  localparam logic [12:0] COUNT_RST   = 13'h0000;

  // ---------------------------------------------------------------
  // Ramp tables
  // ---------------------------------------------------------------
  localparam int         STEPS     = 15;
  localparam logic [3:0] LAST_STEP = 4'he;
  localparam logic [8:0] RAMP_BASE = 9'h05e;
  localparam logic [6:0] WEIGHT [STEPS] = '{7'h78, 7'h38, 7'h23, 7'h18, 7'h12, 7'h0d, 7'h0a, 7'h08,
                                            7'h07, 7'h06, 7'h05, 7'h04, 7'h03, 7'h02, 7'h01};
  // Row index is the select code; code 00 reuses the fourth row
  localparam logic [4:0] STEP_TBL [4][STEPS] = '{
    '{5'h01, 5'h03, 5'h03, 5'h04, 5'h03, 5'h04, 5'h03, 5'h03, 5'h03, 5'h03, 5'h05, 5'h09, 5'h0d, 5'h0f, 5'h16},
    '{5'h02, 5'h05, 5'h02, 5'h01, 5'h01, 5'h01, 5'h01, 5'h01, 5'h01, 5'h01, 5'h02, 5'h03, 5'h0b, 5'h1f, 5'h1f},
    '{5'h01, 5'h04, 5'h04, 5'h03, 5'h02, 5'h02, 5'h02, 5'h02, 5'h02, 5'h02, 5'h04, 5'h06, 5'h0c, 5'h11, 5'h1f},
    '{5'h01, 5'h03, 5'h03, 5'h04, 5'h03, 5'h04, 5'h03, 5'h03, 5'h03, 5'h03, 5'h05, 5'h09, 5'h0d, 5'h0f, 5'h16}};

  typedef enum logic [1:0] {PH_IDLE, PH_ACCEL, PH_CRUISE, PH_DECEL} phase_e;

endpackage

// ---- pkg/word_if.sv ----
`timescale 1ns/1ps
interface word_if;
  logic [15:0] word;
  logic        valid;
  modport rx   (output word, output valid);
  modport core (input word, input valid);
endinterface

// ---- hdl/serial_word_rx.sv ----
`timescale 1ns/1ps
module serial_word_rx (
  input  wire logic i_core_clk,
  input  wire logic i_rstn,
  input  wire logic i_sclk,
  input  wire logic i_sdata,
  input  wire logic i_latch,
  word_if.rx        wbus
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0]  s1_reg;
  logic [2:0]  s2_reg;
  logic        sclk_d_reg;
  logic        latch_d_reg;
  logic [15:0] shift_reg;
  logic [15:0] word_reg;
  logic        valid_reg;

  wire sclk_rise  = s2_reg[0] & ~sclk_d_reg;
  wire latch_rise = s2_reg[2] & ~latch_d_reg;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_reg      <= 3'h0;
      s2_reg      <= 3'h0;
      sclk_d_reg  <= 1'b0;
      latch_d_reg <= 1'b0;
    end else begin
      s1_reg      <= {i_latch, i_sdata, i_sclk};
      s2_reg      <= s1_reg;
      sclk_d_reg  <= s2_reg[0];
      latch_d_reg <= s2_reg[2];
    end
  end

  // ---------------------------------------------------------------
  // Shift and commit
  // ---------------------------------------------------------------
  // Data and clock share the same sync depth, so sampling stays aligned
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      shift_reg <= 16'h0000;
      word_reg  <= 16'h0000;
      valid_reg <= 1'b0;
    end else begin
      if (sclk_rise) begin
        shift_reg <= {s2_reg[1], shift_reg[15:1]};
      end
      valid_reg <= latch_rise;
      if (latch_rise) begin
        word_reg <= shift_reg;
      end
    end
  end

  assign wbus.word  = word_reg;
  assign wbus.valid = valid_reg;

endmodule // serial_word_rx

// ---- hdl/step_pulse_profile_generator.sv ----
`timescale 1ns/1ps
// Function
// - Fixed weights 120,56,35,24,18,13,10,8,7,6,5,4,3,2,1 for ramp steps one to fifteen.
// - Step period is base plus increment times weight, repeated the table's pulse count.
// - Increment is base divided by 2,4,8,16,20 or 32 from D4..D2.
// - D6..D5 select abrupt, gentle, linear or fourth pulse-count table.
// - D8..D7 scale each step's pulse count by one, two or four.
// - Da enables acceleration, D9 enables deceleration, independently.
// - Both ramps with short count: decelerate from half count, mirroring acceleration.
// - Acceleration only with short count: stop at the intermediate rate reached.
// - Deceleration only with short count: follow the curve, stop before target rate.
// - Top bits 100 load a thirteen-bit period in one-microsecond units.
// - Period zero emits no pulses and keeps drive state.
// - Top bits 101 load a thirteen-bit pulse count.
// - Count is multiplied before counting; monitor reports the multiplied count.
// - Count zero emits no pulses and holds drive state.
// - D1..D0 give multiplier one, two or four.
// - Default profile word: no ramps, multiplier one.
module step_pulse_profile_generator (
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_sclk,
  input  wire logic        i_sdata,
  input  wire logic        i_latch,
  output logic             o_logic_monitor_out_a,
  output logic             o_busy,
  output logic [14:0]      o_total_pulses
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [12:0] ref_inc(input logic [12:0] base, input logic [2:0] code);
    case (code)
      3'h1:    ref_inc = base >> 1;
      3'h3:    ref_inc = base >> 2;
      3'h5:    ref_inc = base >> 4;
      3'h6:    ref_inc = base / 13'h0014;
      3'h7:    ref_inc = base >> 5;
      default: ref_inc = base >> 3;
    endcase
  endfunction

  function automatic logic [6:0] step_full(input logic [1:0] tb, input logic [1:0] sh, input logic [3:0] ix);
    step_full = 7'(STEP_TBL_AT(tb, ix)) << sh;
  endfunction

  function automatic logic [4:0] STEP_TBL_AT(input logic [1:0] tb, input logic [3:0] ix);
    STEP_TBL_AT = step_pkg::STEP_TBL[tb][ix];
  endfunction

  // ---------------------------------------------------------------
  // Serial word port
  // ---------------------------------------------------------------
  word_if wbus ();

  serial_word_rx u_rx (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_sclk     (i_sclk),
    .i_sdata    (i_sdata),
    .i_latch    (i_latch),
    .wbus       (wbus.rx)
  );

  // ---------------------------------------------------------------
  // Configuration decode
  // ---------------------------------------------------------------
  logic [12:0]          prof_reg;
  logic [12:0]          period_reg;
  logic [12:0]          count_reg;
  logic [14:0]          total_reg;
  logic [14:0]          emitted_reg;
  step_pkg::phase_e     phase_reg;
  step_pkg::phase_e     phase_next;
  logic [3:0]           idx_reg;
  logic [3:0]           idx_next;
  logic [6:0]           inner_reg;
  logic [6:0]           inner_next;
  logic [19:0]          tmr_reg;
  logic [6:0]           pre_reg;
  logic                 pulse_reg;

  wire [2:0]  sel      = wbus.word[step_pkg::SEL_LSB +: 3];
  wire [12:0] fld      = wbus.word[step_pkg::FIELD_W-1:0];
  wire        wr_prof  = wbus.valid && (sel == step_pkg::SEL_PROFILE);
  wire        wr_per   = wbus.valid && (sel == step_pkg::SEL_PERIOD);
  wire        wr_cnt   = wbus.valid && (sel == step_pkg::SEL_COUNT);
  wire [1:0]  mcode    = prof_reg[step_pkg::MULT_LSB +: 2];
  wire [2:0]  dcode    = prof_reg[step_pkg::DIV_LSB +: 3];
  wire [1:0]  tcode    = prof_reg[step_pkg::TBL_LSB +: 2];
  wire [1:0]  scode    = prof_reg[step_pkg::TIME_LSB +: 2];
  wire        dec_en   = prof_reg[step_pkg::DEC_EN_BIT];
  wire        acc_en   = prof_reg[step_pkg::ACC_EN_BIT];
  wire [1:0]  m_sh     = (mcode == 2'h3) ? 2'h2 : ((mcode == 2'h2) ? 2'h1 : 2'h0);
  wire [1:0]  t_sh     = (scode == 2'h3) ? 2'h2 : ((scode == 2'h2) ? 2'h1 : 2'h0);
  wire [14:0] ramp_len = 15'(step_pkg::RAMP_BASE) << t_sh;
  wire [14:0] tot_new  = 15'(fld) << m_sh;
  wire        start    = wr_cnt && (fld != 13'h0000) && (period_reg != 13'h0000);

  // ---------------------------------------------------------------
  // Pulse timing
  // ---------------------------------------------------------------
  wire        ramping  = (phase_reg == step_pkg::PH_ACCEL) || (phase_reg == step_pkg::PH_DECEL);
  wire [6:0]  weight   = ramping ? step_pkg::WEIGHT[idx_reg] : 7'h00;
  wire [12:0] inc      = ref_inc(period_reg, dcode);
  wire [19:0] cur_per  = 20'(period_reg) + 20'(inc) * 20'(weight);
  wire        tick     = (pre_reg == 7'(step_pkg::UNIT_CYC - 1));
  wire        running  = (phase_reg != step_pkg::PH_IDLE);
  wire        fire     = running && tick && (period_reg != 13'h0000) && (tmr_reg + 20'h1 >= cur_per);

  // ---------------------------------------------------------------
  // Profile sequencing
  // ---------------------------------------------------------------
  wire [14:0] emit_n     = emitted_reg + 15'h1;
  wire [14:0] rem_n      = total_reg - emit_n;
  wire [6:0]  full_cur   = step_full(tcode, t_sh, idx_reg);
  wire [6:0]  full_prev  = step_full(tcode, t_sh, idx_reg - 4'h1);
  wire [6:0]  full_last  = step_full(tcode, t_sh, step_pkg::LAST_STEP);
  wire [6:0]  inner_a    = inner_reg + 7'h1;
  wire        adv        = (inner_a == full_cur);
  wire        short_both = acc_en && dec_en && (total_reg < (ramp_len << 1));
  wire        trig_pt    = short_both ? (emit_n == (total_reg >> 1)) : (rem_n == ramp_len);
  wire        trig       = dec_en && (phase_reg != step_pkg::PH_DECEL) && trig_pt;
  wire        dec_now    = !acc_en && dec_en && (tot_new <= ramp_len);

  always_comb begin
    phase_next = phase_reg;
    idx_next   = idx_reg;
    inner_next = inner_reg;
    if (start) begin
      if (acc_en) begin
        phase_next = step_pkg::PH_ACCEL;
        idx_next   = 4'h0;
        inner_next = 7'h00;
      end else if (dec_now) begin
        phase_next = step_pkg::PH_DECEL;
        idx_next   = step_pkg::LAST_STEP;
        inner_next = full_last;
      end else begin
        phase_next = step_pkg::PH_CRUISE;
      end
    end else if (fire) begin
      if (emit_n == total_reg) begin
        phase_next = step_pkg::PH_IDLE;
      end else if (trig) begin
        phase_next = step_pkg::PH_DECEL;
        if (phase_reg == step_pkg::PH_ACCEL) begin
          inner_next = inner_a;
        end else begin
          idx_next   = step_pkg::LAST_STEP;
          inner_next = full_last;
        end
      end else begin
        unique case (phase_reg)
          step_pkg::PH_ACCEL: begin
            inner_next = adv ? 7'h00 : inner_a;
            if (adv && idx_reg == step_pkg::LAST_STEP) begin
              phase_next = step_pkg::PH_CRUISE;
            end else if (adv) begin
              idx_next = idx_reg + 4'h1;
            end
          end
          step_pkg::PH_DECEL: begin
            if (inner_reg > 7'h01 || idx_reg == 4'h0) begin
              inner_next = inner_reg - 7'h1;
            end else begin
              idx_next   = idx_reg - 4'h1;
              inner_next = full_prev;
            end
          end
          step_pkg::PH_CRUISE: begin
            inner_next = inner_reg;
          end
          step_pkg::PH_IDLE: begin
            inner_next = inner_reg;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prof_reg   <= step_pkg::PROFILE_RST;
      period_reg <= step_pkg::PERIOD_RST;
      count_reg  <= step_pkg::COUNT_RST;
    end else begin
      if (wr_prof) prof_reg <= fld;
      if (wr_per)  period_reg <= fld;
      if (wr_cnt)  count_reg <= fld;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      total_reg   <= 15'h0000;
      emitted_reg <= 15'h0000;
      phase_reg   <= step_pkg::PH_IDLE;
      idx_reg     <= 4'h0;
      inner_reg   <= 7'h00;
      tmr_reg     <= 20'h00000;
      pre_reg     <= 7'h00;
      pulse_reg   <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      idx_reg   <= idx_next;
      inner_reg <= inner_next;
      pulse_reg <= fire;
      pre_reg   <= (start || tick) ? 7'h00 : pre_reg + 7'h1;
      if (start) begin
        total_reg   <= tot_new;
        emitted_reg <= 15'h0000;
        tmr_reg     <= 20'h00000;
      end else begin
        if (fire) emitted_reg <= emit_n;
        if (fire) tmr_reg <= 20'h00000;
        else if (tick && running) tmr_reg <= tmr_reg + 20'h1;
      end
    end
  end

  // A zero count word leaves the last multiplied figure on the monitor bus
  assign o_logic_monitor_out_a = pulse_reg;
  assign o_busy                = running;
  assign o_total_pulses        = total_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  first_weight_a: assert property (phase_reg == step_pkg::PH_ACCEL && idx_reg == 4'h0 |-> cur_per == 20'(period_reg) + 20'(inc) * 20'h78) else $error("first step weight wrong");
  div_eight_a: assert property (dcode == 3'h4 |-> inc == (period_reg >> 3)) else $error("divisor eight wrong");
  div_twenty_a: assert property (dcode == 3'h6 |-> inc == period_reg / 13'h0014) else $error("divisor twenty wrong");
  mult_four_a: assert property (start && mcode == 2'h3 |=> o_total_pulses == ($past(15'(fld)) << 2)) else $error("count not multiplied");
  zero_count_a: assert property (wr_cnt && fld == 13'h0000 && !running |=> !running ##1 !running) else $error("zero count started");
  zero_period_a: assert property (period_reg == 13'h0000 |-> !fire) else $error("pulse with zero period");
  no_ramp_a: assert property (start && !acc_en && !dec_en |=> phase_reg == step_pkg::PH_CRUISE) else $error("ramp without enable");
  last_pulse_a: assert property (fire && emit_n == total_reg |=> !running && emitted_reg == total_reg ##1 o_logic_monitor_out_a == 1'b0) else $error("run did not end on count");
  half_mirror_a: assert property (fire && short_both && phase_reg == step_pkg::PH_ACCEL && emit_n == (total_reg >> 1) && emit_n != total_reg |=> phase_reg == step_pkg::PH_DECEL) else $error("no decel at half");
  dec_only_a: assert property (start && dec_now |=> phase_reg == step_pkg::PH_DECEL && idx_reg == step_pkg::LAST_STEP) else $error("short decel not immediate");
  pulse_gap_a: assert property (fire |=> !fire [*8]) else $error("pulses too close");
  period_load_a: assert property (wr_per |=> period_reg == $past(fld)) else $error("period not loaded");
  count_load_a: assert property (wr_cnt |=> count_reg == $past(fld)) else $error("count not loaded");

  accel_run_c: cover property (phase_reg == step_pkg::PH_ACCEL ##[1:1000] phase_reg == step_pkg::PH_CRUISE);
  decel_fire_c: cover property (fire && phase_reg == step_pkg::PH_DECEL);
  short_both_c: cover property (fire && short_both && trig);

endmodule // step_pulse_profile_generator

// ---- tb/host_link.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Host side of the serial configuration link
// ---------------------------------------------------------------
module host_link (
  input  wire logic i_core_clk,
  output logic      o_sclk,
  output logic      o_sdata,
  output logic      o_latch
);
  // Serial clock stands low between words
  initial begin
    o_sclk  = 1'b0;
    o_sdata = 1'b0;
    o_latch = 1'b0;
  end

  // Bit 0 first, one bit per rising serial clock, 160 ns period
  task automatic send(input logic [15:0] word);
    for (int i = 0; i < 16; i++) begin
      o_sdata <= word[i];
      repeat (8) @(posedge i_core_clk);
      o_sclk <= 1'b1;
      repeat (8) @(posedge i_core_clk);
      o_sclk <= 1'b0;
    end
    // Data no longer valid after the word: show the inverse of the last bit
    repeat (4) @(posedge i_core_clk);
    o_sdata <= ~word[15];
    repeat (4) @(posedge i_core_clk);
    o_latch <= 1'b1;
    repeat (8) @(posedge i_core_clk);
    o_latch <= 1'b0;
    // Spacing keeps the latch to next serial clock gap well clear
    repeat (20) @(posedge i_core_clk);
  endtask
endmodule // host_link

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Step pulse generator bench
// ---------------------------------------------------------------
module tb_top;
  logic        i_core_clk;
  logic        i_rstn;
  logic        sclk;
  logic        sdata;
  logic        latch;
  logic        pulse;
  logic        busy;
  logic [14:0] total;
  int          n_mismatch;
  int          num_checks;
  int          cyc = 0;
  int          np = 0;
  int          stamp [64];
  int          mult [4] = '{1, 1, 2, 4};
  int          divs [8] = '{8, 2, 8, 4, 8, 16, 20, 32};
  logic [12:0] tprof [5] = '{13'h02e4, 13'h0204, 13'h02a4, 13'h02c4, 13'h0364};
  int          tcnt [5] = '{24, 24, 33, 33, 46};

  host_link host (
    .i_core_clk (i_core_clk),
    .o_sclk     (sclk),
    .o_sdata    (sdata),
    .o_latch    (latch)
  );

  step_pulse_profile_generator dut (
    .i_core_clk            (i_core_clk),
    .i_rstn                (i_rstn),
    .i_sclk                (sclk),
    .i_sdata               (sdata),
    .i_latch               (latch),
    .o_logic_monitor_out_a (pulse),
    .o_busy                (busy),
    .o_total_pulses        (total)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  // Time stamp of every step pulse, in core cycles
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (pulse === 1'b1) begin
      stamp[np % 64] <= cyc;
      np <= np + 1;
    end
  end

  task automatic end_of_test();
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  // One run: configure, start, then check pulse count and spacing.
  // Gaps from pulse chg onward are one microsecond longer (next ramp step).
  task automatic run(input bit wp, input logic [12:0] prof, input logic [12:0] per, input logic [12:0] cnt,
                     input int exp_np, input int gap, input int chg);
    int k;
    int np0;
    @(posedge i_core_clk);
    if (wp) host.send({step_pkg::SEL_PROFILE, prof});
    host.send({step_pkg::SEL_PERIOD, per});
    np0 = np;
    host.send({step_pkg::SEL_COUNT, cnt});
    #1;
    chk("busy", {31'h0, exp_np != 0}, {31'h0, busy});
    if (exp_np != 0) chk("total", exp_np, {17'h0, total});
    k = 0;
    while (busy !== 1'b0 && k < 60000) begin
      @(posedge i_core_clk);
      k++;
    end
    // A run that never ends shows up here as a mismatch
    chk("idle", 32'h0, {31'h0, busy});
    repeat (5) @(posedge i_core_clk);
    chk("pulses", exp_np, np - np0);
    for (k = 2; k <= exp_np && k < 64; k++)
      chk("gap", ((chg > 0 && k >= chg) ? gap + 1 : gap) * step_pkg::UNIT_CYC,
          stamp[(np0 + k - 1) % 64] - stamp[(np0 + k - 2) % 64]);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    i_rstn     = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (10) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    repeat (5) @(posedge i_core_clk);
    // Untouched profile word: flat rate, count taken as is
    run(1'b0, 13'h0000, 13'h0001, 13'h0003, 3, 1, 0);
    for (int m = 0; m < 4; m++) begin
      run(1'b1, 13'(m), 13'h0001, 13'h0003, 3 * mult[m], 1, 0);
    end
    run(1'b1, 13'h0000, 13'h0000, 13'h0003, 0, 0, 0);
    run(1'b1, 13'h0000, 13'h0001, 13'h0000, 0, 0, 0);
    // Deceleration only, short count: stays at step 15 (weight 1), gap shows the divisor
    for (int d = 0; d < 8; d++) begin
      run(1'b1, 13'h02a0 | 13'(d << 2), 13'h0010, 13'h0002, 2, 16 + 16 / divs[d], 0);
    end
    // Step 15 length shows table and time factor; step 14 adds one microsecond
    for (int t = 0; t < 5; t++) begin
      run(1'b1, tprof[t], 13'h0002, 13'(tcnt[t]), tcnt[t], 3, tcnt[t] - 1);
    end
    // The two decel-only loops above also show that D9 acts without Da
    // Short counts with both ramps, then acceleration only; divisor 32 keeps the gap flat and the run short
    run(1'b1, 13'h06fc, 13'h0002, 13'h0004, 4, 2, 0);
    run(1'b1, 13'h04fc, 13'h0002, 13'h0002, 2, 2, 0);
    end_of_test();
  end

  // Long ramps would hang here without a bound
  initial begin
    repeat (200000) @(posedge i_core_clk);
    n_mismatch++;
    end_of_test();
  end
endmodule // tb_top
